// File: hw/dma_controller.sv
// eight-channel dma controller: axi4-lite registers, one bus master port
// assumes the bus answers each command with one memAck cycle, memErr with it on a bad region
`timescale 1ns/100ps
module dma_controller #(
  parameter int NumCh = dma_pkg::NUM_CH
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // axi4-lite write
  input wire logic [dma_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [dma_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral requests
  input wire logic [NumCh-1:0] hwReq,
  output logic [NumCh-1:0] reqAck,
  // system bus master
  output dma_pkg::mem_cmd_t memCmd,
  input wire logic memAck,
  input wire logic memErr,
  input wire logic [31:0] memRdata,
  // per-channel interrupt lines
  output logic [NumCh-1:0] chanIrq
);

  localparam int IdxW = $clog2(NumCh);

  ////////////////////////////////////////////////////////////////////////////
  // channel state

  // one full register set per channel
  dma_pkg::chan_ctrl_t ctrl_reg [NumCh];
  dma_pkg::chan_setup_t setup_reg [NumCh];
  logic [31:0] pBase_reg [NumCh];
  logic [31:0] mBase_reg [NumCh];
  logic [31:0] pCur_reg [NumCh];
  logic [31:0] mCur_reg [NumCh];
  logic [15:0] cntInit_reg [NumCh];
  logic [15:0] cnt_reg [NumCh];
  logic [3:0] flags_reg [NumCh];
  logic [NumCh-1:0] swPend_reg;
  logic [NumCh-1:0] reqAck_reg;
  logic [NumCh-1:0] chanIrq_reg;

  // bus slave state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // engine state
  dma_pkg::eng_state_t state_reg;
  logic [IdxW-1:0] chSel_reg;
  dma_pkg::mem_cmd_t memCmd_reg;

  logic wrFire;
  logic [31:0] strbMask;
  logic [31:0] wrWord;
  logic [NumCh-1:0] stepDone;
  logic [NumCh-1:0] faultHit;
  logic [NumCh-1:0] pending;
  logic [2*NumCh-1:0] rankVec;
  logic grantValid;
  logic [IdxW-1:0] grantIdx;
  logic [IdxW-1:0] curCh;
  logic srcIsPeriph;
  logic [31:0] srcAddr;
  logic [31:0] dstAddr;
  logic [1:0] srcW;
  logic [1:0] dstW;
  logic [31:0] srcItem;
  logic [31:0] dstData;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    if (w == dma_pkg::WIDTH_8) width_mask = 32'h0000_00ff;
    else if (w == dma_pkg::WIDTH_16) width_mask = 32'h0000_ffff;
    else width_mask = 32'hffff_ffff;
  endfunction : width_mask

  // reserved code 3 is treated as a word
  function automatic logic [31:0] width_bytes(input logic [1:0] w);
    if (w == dma_pkg::WIDTH_8) width_bytes = 32'h0000_0001;
    else if (w == dma_pkg::WIDTH_16) width_bytes = 32'h0000_0002;
    else width_bytes = 32'h0000_0004;
  endfunction : width_bytes

  function automatic logic is_mapped(input logic [11:0] a);
    if (a == dma_pkg::OFS_FLAGS) is_mapped = 1'b1;
    else if (a == dma_pkg::OFS_FLAG_CLR) is_mapped = 1'b1;
    else if (a == dma_pkg::OFS_SW_TRIG) is_mapped = 1'b1;
    else if (a[11:8] != 4'h0 || int'(a[7:5]) >= NumCh || a[1:0] != 2'h0) is_mapped = 1'b0;
    else is_mapped = a[4:0] <= dma_pkg::OFS_MBASE[4:0];
  endfunction : is_mapped

  // trigger and clear words read as zero, so byte merges stay harmless
  function automatic logic [31:0] read_word(input logic [11:0] a);
    int ch;
    ch = int'(a[7:5]);
    read_word = 32'h0000_0000;
    if (a == dma_pkg::OFS_FLAGS) begin
      for (int i = 0; i < NumCh; i++) begin
        read_word[i*dma_pkg::FLAGS_PER_CH +: dma_pkg::FLAGS_PER_CH] = flags_reg[i];
      end
    end else if (!is_mapped(a) || a[11:8] != 4'h0) begin
      read_word = 32'h0000_0000;
    end else if (a[4:0] == dma_pkg::OFS_CTRL[4:0]) begin
      read_word = {28'h0000_000, ctrl_reg[ch]};
    end else if (a[4:0] == dma_pkg::OFS_SETUP[4:0]) begin
      read_word = {21'h0, setup_reg[ch]};
    end else if (a[4:0] == dma_pkg::OFS_COUNT[4:0]) begin
      read_word = {16'h0000, cnt_reg[ch]};
    end else if (a[4:0] == dma_pkg::OFS_PBASE[4:0]) begin
      read_word = pBase_reg[ch];
    end else begin
      read_word = mBase_reg[ch];
    end
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  assign wrFire = !awready_reg && !wready_reg && !bvalid_reg;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strbMask[i*8 +: 8] = {8{wStrb_reg[i]}};
    end
  end

  assign wrWord = (read_word(awAddr_reg) & ~strbMask) | (wData_reg & strbMask);

  // address and data are taken in either order; the write happens once both are held
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= dma_pkg::RESP_OKAY;
      awAddr_reg <= 12'h000;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_reg) begin
        awAddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wrFire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(awAddr_reg) ? dma_pkg::RESP_OKAY : dma_pkg::RESP_DECERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= dma_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= read_word(s_axi_araddr);
        rresp_reg <= is_mapped(s_axi_araddr) ? dma_pkg::RESP_OKAY : dma_pkg::RESP_DECERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel registers

  for (genvar g = 0; g < NumCh; g++) begin : gen_ch
    logic chHit;
    logic ctrlWr;
    logic startNow;
    logic locked;
    logic reloadNow;
    logic [15:0] cntNext;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    logic trig;
    dma_pkg::chan_setup_t setupNext;

    assign chHit = wrFire && awAddr_reg[11:8] == 4'h0 && awAddr_reg[7:5] == 3'(g);
    assign ctrlWr = chHit && awAddr_reg[4:0] == dma_pkg::OFS_CTRL[4:0];
    assign startNow = ctrlWr && wrWord[dma_pkg::CTRL_EN] && !ctrl_reg[g].enable;
    assign locked = ctrl_reg[g].enable;
    assign trig = wrFire && awAddr_reg == dma_pkg::OFS_SW_TRIG && wrWord[g];
    assign rankVec[2*g +: 2] = setup_reg[g].channelRank;
    assign pending[g] = ctrl_reg[g].enable && cnt_reg[g] != 16'h0000 &&
                        (setup_reg[g].copyMode || (hwReq[g] && !reqAck_reg[g]) || swPend_reg[g]);

    always_comb begin
      setupNext = dma_pkg::chan_setup_t'(wrWord[dma_pkg::SETUP_W-1:0]);
      // locked fields keep their value while enabled
      if (locked) begin
        setupNext.dir = setup_reg[g].dir;
        setupNext.loopMode = setup_reg[g].loopMode;
        setupNext.periphAddrStepOn = setup_reg[g].periphAddrStepOn;
        setupNext.memAddrStepOn = setup_reg[g].memAddrStepOn;
      end
      cntNext = cnt_reg[g] - 16'h0001;
      reloadNow = setup_reg[g].loopMode && !setup_reg[g].copyMode && cntNext == 16'h0000;
      flagSet = 4'h0;
      if (stepDone[g]) begin
        // below half of the programmed count
        flagSet[dma_pkg::FLAG_HALF] = {cntNext, 1'b0} < {1'b0, cntInit_reg[g]};
        flagSet[dma_pkg::FLAG_DONE] = cntNext == 16'h0000;
      end
      flagSet[dma_pkg::FLAG_FAULT] = faultHit[g];
      flagSet[dma_pkg::FLAG_ANY] = flagSet[dma_pkg::FLAG_HALF] | flagSet[dma_pkg::FLAG_DONE] |
                                   flagSet[dma_pkg::FLAG_FAULT];
      flagClr = 4'h0;
      if (wrFire && awAddr_reg == dma_pkg::OFS_FLAG_CLR) begin
        flagClr = wrWord[g*dma_pkg::FLAGS_PER_CH +: dma_pkg::FLAGS_PER_CH];
      end
      // clearing the summary clears the whole nibble
      if (flagClr[dma_pkg::FLAG_ANY]) flagClr = 4'hf;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        ctrl_reg[g] <= dma_pkg::CTRL_RST;
      end else if (ce) begin
        if (ctrlWr) ctrl_reg[g] <= wrWord[3:0];
        // fault stops the channel, even against a same-cycle write
        if (faultHit[g]) ctrl_reg[g].enable <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        setup_reg[g] <= dma_pkg::SETUP_RST;
      end else if (ce && chHit && awAddr_reg[4:0] == dma_pkg::OFS_SETUP[4:0]) begin
        setup_reg[g] <= setupNext;
      end
    end

    // sixteen-bit count, up to 65535 items
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        cntInit_reg[g] <= dma_pkg::CNT_RST;
        cnt_reg[g] <= dma_pkg::CNT_RST;
      end else if (ce) begin
        if (chHit && awAddr_reg[4:0] == dma_pkg::OFS_COUNT[4:0] && !locked) begin
          cntInit_reg[g] <= wrWord[15:0];
          cnt_reg[g] <= wrWord[15:0];
        end else if (stepDone[g]) begin
          // reload at zero in loop mode
          cnt_reg[g] <= reloadNow ? cntInit_reg[g] : cntNext;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        pBase_reg[g] <= dma_pkg::ADDR_RST;
        pCur_reg[g] <= dma_pkg::ADDR_RST;
      end else if (ce) begin
        if (chHit && awAddr_reg[4:0] == dma_pkg::OFS_PBASE[4:0] && !locked) begin
          pBase_reg[g] <= wrWord;
          pCur_reg[g] <= wrWord;
        end else if (startNow || (stepDone[g] && reloadNow)) begin
          pCur_reg[g] <= pBase_reg[g];
        end else if (stepDone[g] && setup_reg[g].periphAddrStepOn) begin
          pCur_reg[g] <= pCur_reg[g] + width_bytes(setup_reg[g].periphWidth);
        end
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        mBase_reg[g] <= dma_pkg::ADDR_RST;
        mCur_reg[g] <= dma_pkg::ADDR_RST;
      end else if (ce) begin
        if (chHit && awAddr_reg[4:0] == dma_pkg::OFS_MBASE[4:0] && !locked) begin
          mBase_reg[g] <= wrWord;
          mCur_reg[g] <= wrWord;
        end else if (startNow || (stepDone[g] && reloadNow)) begin
          mCur_reg[g] <= mBase_reg[g];
        end else if (stepDone[g] && setup_reg[g].memAddrStepOn) begin
          mCur_reg[g] <= mCur_reg[g] + width_bytes(setup_reg[g].memWidth);
        end
      end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        flags_reg[g] <= dma_pkg::FLAGS_RST;
        swPend_reg[g] <= 1'b0;
        reqAck_reg[g] <= 1'b0;
        chanIrq_reg[g] <= 1'b0;
      end else if (ce) begin
        flags_reg[g] <= (flags_reg[g] & ~flagClr) | flagSet;
        swPend_reg[g] <= (swPend_reg[g] & ~(stepDone[g] | faultHit[g])) | trig;
        reqAck_reg[g] <= stepDone[g] | faultHit[g];
        chanIrq_reg[g] <= (flags_reg[g][dma_pkg::FLAG_HALF] & ctrl_reg[g].halfIrqOn) |
                          (flags_reg[g][dma_pkg::FLAG_DONE] & ctrl_reg[g].doneIrqOn) |
                          (flags_reg[g][dma_pkg::FLAG_FAULT] & ctrl_reg[g].faultIrqOn);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbiter and transfer engine

  dma_rank_arbiter #(
    .NumCh(NumCh),
    .IdxW(IdxW)
  ) u_arb (
    .pending(pending),
    .rank(rankVec),
    .grantValid(grantValid),
    .grantIdx(grantIdx)
  );

  assign curCh = (state_reg == dma_pkg::ST_IDLE) ? grantIdx : chSel_reg;
  // copy mode reads through the peripheral pointer
  assign srcIsPeriph = setup_reg[curCh].copyMode || !setup_reg[curCh].dir;
  // any address is a legal target; the bus reports bad regions
  assign srcAddr = srcIsPeriph ? pCur_reg[curCh] : mCur_reg[curCh];
  assign dstAddr = srcIsPeriph ? mCur_reg[curCh] : pCur_reg[curCh];
  assign srcW = srcIsPeriph ? setup_reg[curCh].periphWidth : setup_reg[curCh].memWidth;
  assign dstW = srcIsPeriph ? setup_reg[curCh].memWidth : setup_reg[curCh].periphWidth;
  assign srcItem = (memRdata >> {srcAddr[1:0], 3'b000}) & width_mask(srcW);
  assign dstData = (srcItem & width_mask(dstW)) << {dstAddr[1:0], 3'b000};

  always_comb begin
    for (int i = 0; i < NumCh; i++) begin
      stepDone[i] = state_reg == dma_pkg::ST_WRITE && memCmd_reg.valid && memAck &&
                    !memErr && chSel_reg == IdxW'(i);
      faultHit[i] = state_reg != dma_pkg::ST_IDLE && memCmd_reg.valid && memAck &&
                    memErr && chSel_reg == IdxW'(i);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= dma_pkg::ST_IDLE;
      chSel_reg <= '0;
      memCmd_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        dma_pkg::ST_IDLE: begin
          if (grantValid) begin
            chSel_reg <= grantIdx;
            memCmd_reg <= '{valid: 1'b1, write: 1'b0, size: srcW, addr: srcAddr,
                            wdata: 32'h0000_0000};
            state_reg <= dma_pkg::ST_READ;
          end
        end
        dma_pkg::ST_READ: begin
          if (memAck && memErr) begin
            memCmd_reg.valid <= 1'b0;
            state_reg <= dma_pkg::ST_IDLE;
          end else if (memAck) begin
            memCmd_reg <= '{valid: 1'b1, write: 1'b1, size: dstW, addr: dstAddr,
                            wdata: dstData};
            state_reg <= dma_pkg::ST_WRITE;
          end
        end
        dma_pkg::ST_WRITE: begin
          if (memAck) begin
            memCmd_reg.valid <= 1'b0;
            state_reg <= dma_pkg::ST_IDLE;
          end
        end
        default: begin
          memCmd_reg.valid <= 1'b0;
          state_reg <= dma_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign reqAck = reqAck_reg;
  assign memCmd = memCmd_reg;
  assign chanIrq = chanIrq_reg;

endmodule : dma_controller

// File: hw/dma_pkg.sv
// constants, field layouts and carrier types for the eight-channel dma controller
// assumes one clock domain and an axi4-lite register port with 12 address bits
//
// Summary of operation
// - eight general-purpose channels, each configured on its own
// - each channel serves its hardware request line or a software trigger
// - all requests meet one arbiter that grants a single channel at a time
// - two-bit rank per channel; the highest pending rank wins
// - equal ranks go to the lowest channel number
// - each service reads one item, writes it, then decrements the remaining count
// - first transfer starts at the programmed peripheral and memory base addresses
// - copy_mode 0: dir 0 peripheral to memory, dir 1 memory to peripheral; 1 memory copy
// - copy mode runs as soon as the channel is enabled, no request needed
// - loop_mode reload is ignored while copy_mode is set
// - bases, count, dir, loop and step bits accept writes only while disabled
// - loop_mode reloads count and both pointers at zero and keeps running
// - half_done_flag set once remaining count drops below half; irq if enabled
// - done_flag set when remaining count reaches zero; irq if enabled
// - bus error on a channel access sets fault_flag; irq if enabled
// - a fault clears the channel enable bit
// - any_event_flag set with any half, done or fault event of the channel
// - transfer count programmable up to 65535 items
// - any bus target may be source or destination
// - separate step enables advance each pointer per item, else it stays fixed
// - 8/16/32-bit widths; pointers step by own width; zero-extend or truncate
package dma_pkg;

  localparam int NUM_CH = 8;
  localparam int AXI_AW = 12;
  localparam int CNT_W = 16;

  // register offsets; channel n sits at n times the stride
  localparam int CH_SHIFT = 5;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SETUP = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;
  localparam logic [11:0] OFS_PBASE = 12'h00c;
  localparam logic [11:0] OFS_MBASE = 12'h010;
  localparam logic [11:0] OFS_FLAGS = 12'h100;
  localparam logic [11:0] OFS_FLAG_CLR = 12'h104;
  localparam logic [11:0] OFS_SW_TRIG = 12'h108;

  // flag nibble layout, one nibble per channel
  localparam int FLAG_ANY = 0;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_FAULT = 3;
  localparam int FLAGS_PER_CH = 4;

  // control bit position of enable
  localparam int CTRL_EN = 0;
  localparam int SETUP_W = 11;

  // item width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // values after reset
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [10:0] SETUP_RST = 11'h000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic faultIrqOn;
    logic doneIrqOn;
    logic halfIrqOn;
    logic enable;
  } chan_ctrl_t;

  typedef struct packed {
    logic copyMode;
    logic [1:0] channelRank;
    logic [1:0] memWidth;
    logic [1:0] periphWidth;
    logic memAddrStepOn;
    logic periphAddrStepOn;
    logic loopMode;
    logic dir;
  } chan_setup_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } eng_state_t;

endpackage : dma_pkg

// File: hw/dma_rank_arbiter.sv
// rank arbiter: picks one pending channel per cycle
// assumes pending and rank are stable while the engine samples the grant
`timescale 1ns/100ps
module dma_rank_arbiter #(
  parameter int NumCh = dma_pkg::NUM_CH,
  parameter int IdxW = $clog2(NumCh)
) (
  // requests
  input wire logic [NumCh-1:0] pending,
  input wire logic [2*NumCh-1:0] rank,
  // grant
  output logic grantValid,
  output logic [IdxW-1:0] grantIdx
);

  logic [1:0] bestRank;

  // scan downward so ties land on the lowest channel
  always_comb begin
    grantValid = 1'b0;
    grantIdx = '0;
    bestRank = 2'h0;
    for (int i = NumCh - 1; i >= 0; i--) begin
      if (pending[i] && (!grantValid || rank[2*i +: 2] >= bestRank)) begin
        grantValid = 1'b1;
        grantIdx = IdxW'(i);
        bestRank = rank[2*i +: 2];
      end
    end
  end

endmodule : dma_rank_arbiter

// File: dv/dma_bus_model.sv
// system bus memory beside the dma master port: answers each command with one memAck
// assumes memCmd is held until memAck; slow adds wait cycles; top nibble 0xf is reserved
`timescale 1ns/100ps
module dma_bus_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // command side
  input wire dma_pkg::mem_cmd_t memCmd,
  input wire logic slow,
  // answer side
  output logic memAck,
  output logic memErr,
  output logic [31:0] memRdata
);
  logic [1:0] waitCnt;
  logic go;
  assign go = memCmd.valid && !memAck && (!slow || waitCnt == 2'h3);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      memAck <= 1'b0;
      memErr <= 1'b0;
      memRdata <= 32'h0000_0000;
      waitCnt <= 2'h0;
    end else begin
      memAck <= go;
      memErr <= go && memCmd.addr[31:28] == 4'hf;
      waitCnt <= (memCmd.valid && !memAck) ? waitCnt + 2'h1 : 2'h0;
      // data lines toggle outside an answer so stale words never look valid
      memRdata <= go ? {memCmd.addr[31:2], 2'h0} ^ 32'h5a5a_5a5a : ~memRdata;
    end
  end
endmodule : dma_bus_model

// File: dv/dma_controller_chk.sv
// port checker for the dma controller, bound to every instance
// assumes ce stays high, so no cycle is frozen
`timescale 1ns/100ps
module dma_controller_chk #(
  parameter int NumCh = dma_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NumCh-1:0] reqAck,
  input wire dma_pkg::mem_cmd_t memCmd,
  input wire logic memAck,
  input wire logic memErr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read slot not freed");
  chk_cmd_holds: assert property (memCmd.valid && !memAck |=> $stable(memCmd))
    else $error("bus command changed before answer");
  chk_write_follows: assert property (
    memCmd.valid && !memCmd.write && memAck && !memErr |=> memCmd.valid && memCmd.write)
    else $error("item write missing after read");
  chk_fault_stops: assert property (
    memCmd.valid && !memCmd.write && memAck && memErr |=> !memCmd.valid)
    else $error("write issued after faulty read");
  chk_ack_one_grant: assert property (
    memCmd.valid && memCmd.write && memAck |=> !memCmd.valid && $onehot(reqAck))
    else $error("item end without single channel ack");
endmodule : dma_controller_chk
bind dma_controller dma_controller_chk #(.NumCh(NumCh)) i_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .reqAck(reqAck), .memCmd(memCmd),
  .memAck(memAck), .memErr(memErr));

// File: dv/multi_channel_dma_controller_bench.sv
// register-level bench for the dma controller with a bus memory model
// assumes the bind in the checker file; ce and wstrb are held fixed
`timescale 1ns/100ps
module multi_channel_dma_controller_bench;
  logic sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, memRdata;
  logic [7:0] hwReq = 8'h00, reqAck, chanIrq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, memAck, memErr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  dma_pkg::mem_cmd_t memCmd;
  int error_cnt = 0, n_checks = 0, cycles = 0;
  dma_controller i_dut (.sys_clk, .reset_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hwReq, .reqAck, .memCmd,
    .memAck, .memErr, .memRdata, .chanIrq);
  dma_bus_model i_mem (.sys_clk, .reset_n, .memCmd, .slow, .memAck, .memErr, .memRdata);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask : axw
  task axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    forever begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask : axr
  task prog(input int n, input logic [10:0] su, input logic [15:0] c,
    input logic [31:0] pb, input logic [31:0] mb, input logic [3:0] ct);
    logic [11:0] b;
    b = 12'(n) << dma_pkg::CH_SHIFT;
    axw(b | dma_pkg::OFS_SETUP, {21'h0, su});
    axw(b | dma_pkg::OFS_COUNT, {16'h0, c});
    axw(b | dma_pkg::OFS_PBASE, pb);
    axw(b | dma_pkg::OFS_MBASE, mb);
    axw(b | dma_pkg::OFS_CTRL, {28'h0, ct});
  endtask : prog
  // request held until the item write is answered, so it is not served twice
  task svc(input int ch, input logic [31:0] ea, input logic [31:0] ed);
    @(posedge sys_clk);
    hwReq[ch] <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (memCmd.valid && memCmd.write && memAck) break;
    end
    hwReq[ch] <= 1'b0;
    cmp("write addr", ea, memCmd.addr);
    cmp("write data", ed, memCmd.wdata);
  endtask : svc
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    axr(12'h0a4, 32'h0000_0000, dma_pkg::RESP_OKAY);
    axr(12'h0fc, 32'h0000_0000, dma_pkg::RESP_DECERR);
    axw(12'h0a8, 32'h0000_ffff);
    axr(12'h0a8, 32'h0000_ffff, dma_pkg::RESP_OKAY);
    prog(0, 11'h0ae, 16'h0002, 32'h0000_0100, 32'h0000_0200, 4'h7);
    axw(12'h008, 32'h0000_0009);
    axr(12'h008, 32'h0000_0002, dma_pkg::RESP_OKAY);
    for (int k = 0; k < 2; k++)
      svc(0, 32'h200 + 32'(4 * k), (32'h100 + 32'(4 * k)) ^ 32'h5a5a_5a5a);
    axr(12'h100, 32'h0000_0007, dma_pkg::RESP_OKAY);
    cmp("irq", 32'h0000_0001, {24'h0, chanIrq});
    axw(12'h104, 32'h0000_0001);
    axr(12'h100, 32'h0000_0000, dma_pkg::RESP_OKAY);
    svc(0, 32'h0000_0200, 32'h5a5a_5b5a);
    axw(12'h108, 32'h0000_0001);
    axw(12'h000, 32'h0000_0000);
    prog(1, 11'h040, 16'h0001, 32'h0000_0111, 32'h0000_0212, 4'h1);
    prog(2, 11'h3a0, 16'h0001, 32'h0000_0120, 32'h0000_0220, 4'h1);
    prog(3, 11'h3a1, 16'h0001, 32'h0000_0130, 32'h0000_0230, 4'h1);
    @(posedge sys_clk);
    hwReq <= 8'h0e;
    svc(2, 32'h0000_0220, 32'h5a5a_5b7a);
    svc(3, 32'h0000_0130, 32'h5a5a_586a);
    svc(1, 32'h0000_0212, 32'h005b_0000);
    slow <= 1'b1;
    prog(4, 11'h4a0, 16'h0001, 32'hf000_0000, 32'h0000_0240, 4'h9);
    while (reqAck[4] !== 1'b1) @(posedge sys_clk);
    axr(12'h080, 32'h0000_0008, dma_pkg::RESP_OKAY);
    axr(12'h100, 32'h0009_7777, dma_pkg::RESP_OKAY);
    cmp("irq", 32'h0000_0010, {24'h0, chanIrq});
    wrap_up();
  end
endmodule : multi_channel_dma_controller_bench
